// ---- rtl/qupin_irda.sv ----
// Infrared pulse encoder and decoder for one channel
module qupin_irda (
   input  wire logic i_mclk,
   input  wire logic i_rst_b,
   input  wire logic i_tick16,       // Sixteenth-bit tick
   input  wire logic i_tx_data,      // Serial transmit bit
   input  wire logic i_tx_bit_start, // Start of a transmit bit
   input  wire logic i_ir_rx,        // Synchronised, polarity-corrected receive
   output logic      o_ir_pulse,     // Encoded transmit, low when idle
   output logic      o_rx_nrz        // Decoded receive, high when idle
);

   // ************************************************************
   // Encoder
   // ************************************************************
   logic [qupin_pkg::TICK_W-1:0] pcnt;
   logic [qupin_pkg::TICK_W-1:0] next_pcnt;
   wire                          p_start = i_tx_bit_start & ~i_tx_data;
   wire                          p_step  = i_tick16 & (pcnt != qupin_pkg::TICKS_ZERO);

   // A zero bit starts a short pulse, a one bit sends nothing
   assign next_pcnt = p_start ? qupin_pkg::IR_PULSE_TICKS :
                      p_step  ? pcnt - qupin_pkg::TICK_ONE : pcnt;

   // Pulse counter and encoded output
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pcnt       <= qupin_pkg::TICKS_ZERO;
         o_ir_pulse <= qupin_pkg::TX_IDLE_IR;
      end else begin
         pcnt       <= next_pcnt;
         o_ir_pulse <= (next_pcnt != qupin_pkg::TICKS_ZERO);
      end
   end

   // ************************************************************
   // Decoder
   // ************************************************************
   logic                         ir_prev;
   logic [qupin_pkg::TICK_W-1:0] dcnt;
   logic [qupin_pkg::TICK_W-1:0] next_dcnt;
   wire                          d_rise = i_ir_rx & ~ir_prev;
   wire                          d_step = i_tick16 & (dcnt != qupin_pkg::TICKS_ZERO);

   // Each received pulse becomes one whole low bit
   assign next_dcnt = d_rise ? qupin_pkg::BIT_TICKS :
                      d_step ? dcnt - qupin_pkg::TICK_ONE : dcnt;

   // Edge history, bit stretcher and decoded output
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ir_prev  <= qupin_pkg::PIN_IDLE_HIGH;  // Same as synchroniser reset, no false rise
         dcnt     <= qupin_pkg::TICKS_ZERO;
         o_rx_nrz <= qupin_pkg::TX_IDLE_STD;
      end else begin
         ir_prev  <= i_ir_rx;
         dcnt     <= next_dcnt;
         o_rx_nrz <= (next_dcnt == qupin_pkg::TICKS_ZERO);
      end
   end

endmodule : qupin_irda

// ---- rtl/qupin_pkg.sv ----
// Shared constants and carrier types for the quad UART pin interface
package qupin_pkg;

   // ************************************************************
   // Channel count and status word layout
   // ************************************************************
   localparam int           CHANNELS    = 4;
   localparam int           STAT_WIDTH  = 8;
   localparam int           STAT_TX_LSB = 0;  // Inverted tx ready pins, A..D
   localparam int           STAT_RX_LSB = 4;  // Plain rx ready pins, A..D

   // ************************************************************
   // Reset and idle levels
   // ************************************************************
   localparam logic         TX_IDLE_STD   = 1'b1;  // Standard line idles high
   localparam logic         TX_IDLE_IR    = 1'b0;  // Infrared line idles low
   localparam logic         RX_IDLE_IR    = 1'b0;  // Infrared receive idles low
   localparam logic         MODEM_OFF_N   = 1'b1;  // Active-low modem outputs off
   localparam logic         READY_OFF_N   = 1'b1;  // Active-low ready outputs off
   localparam logic         PIN_IDLE_HIGH = 1'b1;  // Synchroniser reset for high pins

   // ************************************************************
   // Infrared timing in sixteenth-bit ticks
   // ************************************************************
   localparam int           TICK_W         = 5;
   localparam logic [4:0]   IR_PULSE_TICKS = 5'h03;  // Three sixteenths of a bit
   localparam logic [4:0]   BIT_TICKS      = 5'h10;  // One whole bit
   localparam logic [4:0]   TICKS_ZERO     = 5'h00;
   localparam logic [4:0]   TICK_ONE       = 5'h01;

   // ************************************************************
   // Per-channel carriers
   // ************************************************************
   // Control bits that software keeps in the channel registers
   typedef struct packed {
      logic ir_en;        // Modem control bit 6: infrared on tx and rx pins
      logic rx_inv;       // Feature control bit 2: invert infrared receive
      logic rts_bit;      // Modem control bit 1: request-to-send asserted
      logic auto_rts_en;  // Enhanced feature bit 6
      logic auto_cts_en;  // Enhanced feature bit 7
      logic cts_irq_en;   // Interrupt enable bit 7
      logic dtr_bit;      // Modem control bit 0: terminal ready asserted
   } qupin_ctrl_t;

   // State that the channel core hands to the pins
   typedef struct packed {
      logic tx_data;       // Serial transmit bit, high when idle
      logic tx_bit_start;  // One-cycle pulse at each bit start
      logic tx_ready;      // Transmit FIFO or holding register ready
      logic rx_ready;      // Receive FIFO or holding register ready
      logic rts_allow;     // Flow control threshold still allows sending
   } qupin_core_t;

   // What the pins hand back to the channel core
   typedef struct packed {
      logic rx_data;     // Decoded serial receive bit, high when idle
      logic cts;         // Clear-to-send asserted, active high
      logic dsr;         // Data-set-ready asserted, active high
      logic tx_hold;     // Automatic flow control stops the transmitter
      logic cts_change;  // One-cycle pulse on a clear-to-send change
   } qupin_sense_t;

endpackage : qupin_pkg

// ---- rtl/qupin_top.sv ----
// Serial, modem and ready-status pin logic of a four-channel UART
module qupin_top #(
   parameter int CHANNELS = qupin_pkg::CHANNELS
) (
   input  wire logic                        i_mclk,
   input  wire logic                        i_rst_b,
   // Core side, same clock
   input  wire logic                        i_tick16,
   input  qupin_pkg::qupin_ctrl_t           i_ctrl     [CHANNELS],
   input  qupin_pkg::qupin_core_t           i_core     [CHANNELS],
   output qupin_pkg::qupin_sense_t          o_sense    [CHANNELS],
   // Serial and modem pins
   output logic [CHANNELS-1:0]              o_tx,
   output logic [CHANNELS-1:0]              o_infrared_tx_out,
   input  wire logic [CHANNELS-1:0]         i_rx,
   output logic [CHANNELS-1:0]              o_rts_n,
   input  wire logic [CHANNELS-1:0]         i_cts_n,
   output logic [CHANNELS-1:0]              o_dtr_n,
   input  wire logic [CHANNELS-1:0]         i_dsr_n,
   // Ready pins
   output logic [CHANNELS-1:0]              o_chan_tx_ready_n,
   output logic [CHANNELS-1:0]              o_chan_rx_ready_n,
   output logic                             o_tx_ready_n,
   output logic                             o_rx_ready_n,
   // Status word on the data bus
   input  wire logic                        i_status_word_select_n,
   output logic [qupin_pkg::STAT_WIDTH-1:0] o_data,
   output logic                             o_data_oe_n
);

   // ************************************************************
   // Elaboration check
   // ************************************************************
   // The status word has room for exactly four channels
   generate
      if (CHANNELS != 4) begin : g_bad_channels
         $error("qupin_top serves exactly four channels");
      end
   endgenerate

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   localparam int SYNC_W = 3 * CHANNELS + 1;

   logic [SYNC_W-1:0] pin_meta;
   logic [SYNC_W-1:0] pin_sync;
   wire  [SYNC_W-1:0] pin_raw = {i_status_word_select_n, i_dsr_n, i_cts_n, i_rx};

   // Two flops on every pin input; only the second is read
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pin_meta <= {SYNC_W{qupin_pkg::PIN_IDLE_HIGH}};
         pin_sync <= {SYNC_W{qupin_pkg::PIN_IDLE_HIGH}};
      end else begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;
      end
   end

   // Synchronised pin levels by group
   wire [CHANNELS-1:0] rx_s    = pin_sync[CHANNELS-1:0];
   wire [CHANNELS-1:0] cts_n_s = pin_sync[2*CHANNELS-1:CHANNELS];
   wire [CHANNELS-1:0] dsr_n_s = pin_sync[3*CHANNELS-1:2*CHANNELS];
   wire                sel_n_s = pin_sync[SYNC_W-1];

   // ************************************************************
   // Per-channel pin logic
   // ************************************************************
   logic [CHANNELS-1:0] ir_pulse;
   logic [CHANNELS-1:0] ir_nrz;
   logic [CHANNELS-1:0] cts_prev;

   generate
      for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
         // Controls and core state of this channel only
         qupin_pkg::qupin_ctrl_t c;
         qupin_pkg::qupin_core_t k;
         assign c = i_ctrl[ch];
         assign k = i_core[ch];

         // Receive polarity fix ahead of the decoder
         wire ir_rx_in = rx_s[ch] ^ c.rx_inv;

         qupin_irda u_irda (
            .i_mclk         (i_mclk),
            .i_rst_b        (i_rst_b),
            .i_tick16       (i_tick16),
            .i_tx_data      (k.tx_data),
            .i_tx_bit_start (k.tx_bit_start),
            .i_ir_rx        (ir_rx_in),
            .o_ir_pulse     (ir_pulse[ch]),
            .o_rx_nrz       (ir_nrz[ch])
         );

         // Transmit pin follows the selected mode
         wire next_tx = c.ir_en ? ir_pulse[ch] : k.tx_data;

         // Receive path: decoder in infrared mode, line as is otherwise
         wire rx_bit = c.ir_en ? ir_nrz[ch] : rx_s[ch];

         // Request-to-send needs the bit; automatic control may only drop it
         wire rts_on = c.rts_bit & (~c.auto_rts_en | k.rts_allow);

         // Clear-to-send level, transmit stop and change event
         wire cts_on     = ~cts_n_s[ch];
         wire tx_hold    = c.auto_cts_en & ~cts_on;
         wire cts_change = c.cts_irq_en & (cts_n_s[ch] ^ cts_prev[ch]);

         // Pin and core-facing registers
         always_ff @(posedge i_mclk or negedge i_rst_b) begin
            if (!i_rst_b) begin
               o_tx[ch]              <= qupin_pkg::TX_IDLE_STD;
               o_infrared_tx_out[ch] <= qupin_pkg::TX_IDLE_IR;
               o_rts_n[ch]           <= qupin_pkg::MODEM_OFF_N;
               o_dtr_n[ch]           <= qupin_pkg::MODEM_OFF_N;
               o_chan_tx_ready_n[ch] <= qupin_pkg::READY_OFF_N;
               o_chan_rx_ready_n[ch] <= qupin_pkg::READY_OFF_N;
               cts_prev[ch]          <= qupin_pkg::PIN_IDLE_HIGH;
               o_sense[ch]           <= '{rx_data: 1'b1, cts: 1'b0, dsr: 1'b0,
                                          tx_hold: 1'b0, cts_change: 1'b0};
            end else begin
               o_tx[ch]              <= next_tx;
               o_infrared_tx_out[ch] <= ir_pulse[ch];
               o_rts_n[ch]           <= ~rts_on;
               o_dtr_n[ch]           <= ~c.dtr_bit;
               o_chan_tx_ready_n[ch] <= ~k.tx_ready;
               o_chan_rx_ready_n[ch] <= ~k.rx_ready;
               cts_prev[ch]          <= cts_n_s[ch];
               o_sense[ch]           <= '{rx_data:    rx_bit,
                                          cts:        cts_on,
                                          dsr:        ~dsr_n_s[ch],
                                          tx_hold:    tx_hold,
                                          cts_change: cts_change};
            end
         end
      end
   endgenerate

   // ************************************************************
   // Combined ready outputs
   // ************************************************************
   // Active low, so any channel low pulls the combined pin low
   wire next_tx_ready_n = &o_chan_tx_ready_n;
   wire next_rx_ready_n = &o_chan_rx_ready_n;

   // ************************************************************
   // Ready status word
   // ************************************************************
   logic [qupin_pkg::STAT_WIDTH-1:0] fifo_ready_status;

   // Transmit pins inverted, receive pins as they stand
   always_comb begin
      fifo_ready_status = '0;
      fifo_ready_status[qupin_pkg::STAT_TX_LSB +: CHANNELS] = ~o_chan_tx_ready_n;
      fifo_ready_status[qupin_pkg::STAT_RX_LSB +: CHANNELS] = o_chan_rx_ready_n;
   end

   // Drive on select alone; release and park at zero otherwise
   wire                             next_oe_n = sel_n_s;
   wire [qupin_pkg::STAT_WIDTH-1:0] next_data =
      sel_n_s ? '0 : fifo_ready_status;

   // Combined pins and bus drivers
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_tx_ready_n <= qupin_pkg::READY_OFF_N;
         o_rx_ready_n <= qupin_pkg::READY_OFF_N;
         o_data       <= '0;
         o_data_oe_n  <= 1'b1;
      end else begin
         o_tx_ready_n <= next_tx_ready_n;
         o_rx_ready_n <= next_rx_ready_n;
         o_data       <= next_data;
         o_data_oe_n  <= next_oe_n;
      end
   end

endmodule : qupin_top

// ---- testbench/qupin_checker.sv ----
// Port assertions for the quad UART pin interface
module qupin_checker #(
   parameter int CHANNELS = 4
) (
   input wire logic                        i_mclk,
   input wire logic                        i_rst_b,
   input wire logic                        i_tick16,
   input qupin_pkg::qupin_ctrl_t           i_ctrl     [CHANNELS],
   input qupin_pkg::qupin_core_t           i_core     [CHANNELS],
   input qupin_pkg::qupin_sense_t          o_sense    [CHANNELS],
   input wire logic [CHANNELS-1:0]         o_tx,
   input wire logic [CHANNELS-1:0]         o_infrared_tx_out,
   input wire logic [CHANNELS-1:0]         i_rx,
   input wire logic [CHANNELS-1:0]         o_rts_n,
   input wire logic [CHANNELS-1:0]         i_cts_n,
   input wire logic [CHANNELS-1:0]         o_dtr_n,
   input wire logic [CHANNELS-1:0]         i_dsr_n,
   input wire logic [CHANNELS-1:0]         o_chan_tx_ready_n,
   input wire logic [CHANNELS-1:0]         o_chan_rx_ready_n,
   input wire logic                        o_tx_ready_n,
   input wire logic                        o_rx_ready_n,
   input wire logic                        i_status_word_select_n,
   input wire logic [qupin_pkg::STAT_WIDTH-1:0] o_data,
   input wire logic                        o_data_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // ***************************************************
   // Per-channel control and core fields as vectors
   // ***************************************************
   logic [CHANNELS-1:0] c_txr;
   logic [CHANNELS-1:0] c_rts;
   logic [CHANNELS-1:0] c_dtr;
   logic [CHANNELS-1:0] c_ir;
   logic [CHANNELS-1:0] c_txd;
   for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
      assign c_txr[g] = i_core[g].tx_ready;
      assign c_rts[g] = i_ctrl[g].rts_bit & (~i_ctrl[g].auto_rts_en | i_core[g].rts_allow);
      assign c_dtr[g] = i_ctrl[g].dtr_bit;
      assign c_ir[g]  = i_ctrl[g].ir_en;
      assign c_txd[g] = i_core[g].tx_data;
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);

   // ***************************************************
   // Status select sequences
   // ***************************************************
   sequence sel_on;
      !i_status_word_select_n [*3];
   endsequence
   sequence sel_off;
      i_status_word_select_n [*3];
   endsequence

   tx_combined_a: assert property (o_tx_ready_n == $past(&o_chan_tx_ready_n))
      else $error("combined tx ready wrong");
   rx_combined_a: assert property (o_rx_ready_n == $past(&o_chan_rx_ready_n))
      else $error("combined rx ready wrong");
   chan_ready_a: assert property ($past(i_rst_b) |-> o_chan_tx_ready_n == ~$past(c_txr))
      else $error("channel tx ready wrong");
   status_word_a: assert property (!o_data_oe_n |->
      o_data == {$past(o_chan_rx_ready_n), ~$past(o_chan_tx_ready_n)})
      else $error("status word wrong");
   status_park_a: assert property (o_data_oe_n |-> o_data == 8'h00)
      else $error("status word driven while off");
   select_drive_a: assert property (sel_on |=> !o_data_oe_n)
      else $error("status word not driven");
   select_release_a: assert property (sel_off |=> o_data_oe_n)
      else $error("status word not released");
   rts_level_a: assert property ($past(i_rst_b) |-> o_rts_n == ~$past(c_rts))
      else $error("request to send wrong");
   dtr_level_a: assert property ($past(i_rst_b) |-> o_dtr_n == ~$past(c_dtr))
      else $error("terminal ready wrong");
   std_tx_a: assert property ($past(i_rst_b) |->
      ((o_tx ^ $past(c_txd)) & ~$past(c_ir)) == 4'h0)
      else $error("standard tx wrong");
   ir_pair_a: assert property ($past(i_rst_b) |->
      ((o_tx ^ o_infrared_tx_out) & $past(c_ir)) == 4'h0)
      else $error("infrared tx differs");
endmodule : qupin_checker

// ---- testbench/qupin_line_partner.sv ----
// Line transceiver model driving the receive and modem input pins
module qupin_line_partner (
   input  wire logic [3:0] i_ir_mode,   // Channel uses infrared line
   input  wire logic [3:0] i_ir_inv,    // Transceiver output is inverted
   input  wire logic [3:0] i_send_mark, // Send an active bit
   input  wire logic [3:0] i_cts_on,
   input  wire logic [3:0] i_dsr_on,
   output logic      [3:0] o_rx,
   output logic      [3:0] o_cts_n,
   output logic      [3:0] o_dsr_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // Standard line idles high, infrared idles low unless inverted
   assign o_rx = (~i_ir_mode & ~i_send_mark) | (i_ir_mode & (i_send_mark ^ i_ir_inv));
   // Modem lines active low
   assign o_cts_n = ~i_cts_on;
   assign o_dsr_n = ~i_dsr_on;
endmodule : qupin_line_partner

// ---- testbench/tb.sv ----
// Self-checking bench for the quad UART pin interface
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_mclk = 1'b0;
   logic i_rst_b = 1'b0;
   logic tick = 1'b0;
   logic sel_n = 1'b1;
   logic [3:0] mark = 4'h0, cts_on = 4'h0, dsr_on = 4'h0;
   logic [3:0] tx, irtx, rx, rts_n, cts_n, dtr_n, dsr_n, ctx_n, crx_n;
   logic [3:0] irm, inv, s_rx, s_cts, s_dsr, s_hold, s_chg;
   logic txr_n, rxr_n, oe_n;
   logic [7:0] data;
   qupin_pkg::qupin_ctrl_t ctrl [4];
   qupin_pkg::qupin_core_t core [4];
   qupin_pkg::qupin_sense_t sense [4];
   int mismatches = 0, comparisons = 0, cycles = 0, tcnt = 0;

   always #2 i_mclk = ~i_mclk;
   // Tick every fourth cycle and hang guard
   always @(posedge i_mclk) begin
      tcnt <= (tcnt + 1) % 4;
      tick <= #1 (tcnt == 3);
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         close_out();
      end
   end
   for (genvar g = 0; g < 4; g++) begin : g_v
      assign {irm[g], inv[g]} = {ctrl[g].ir_en, ctrl[g].rx_inv};
      assign {s_rx[g], s_cts[g], s_dsr[g], s_hold[g], s_chg[g]} = sense[g];
   end

   qupin_top uut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_tick16(tick), .i_ctrl(ctrl),
      .i_core(core), .o_sense(sense), .o_tx(tx), .o_infrared_tx_out(irtx), .i_rx(rx),
      .o_rts_n(rts_n), .i_cts_n(cts_n), .o_dtr_n(dtr_n), .i_dsr_n(dsr_n),
      .o_chan_tx_ready_n(ctx_n), .o_chan_rx_ready_n(crx_n), .o_tx_ready_n(txr_n),
      .o_rx_ready_n(rxr_n), .i_status_word_select_n(sel_n), .o_data(data),
      .o_data_oe_n(oe_n));
   qupin_line_partner far_end (.i_ir_mode(irm), .i_ir_inv(inv), .i_send_mark(mark),
      .i_cts_on(cts_on), .i_dsr_on(dsr_on), .o_rx(rx), .o_cts_n(cts_n), .o_dsr_n(dsr_n));

   task automatic close_out;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask : cyc
   task automatic set_ready(input logic [3:0] t, input logic [3:0] r);
      for (int c = 0; c < 4; c++) begin
         {core[c].tx_ready, core[c].rx_ready} = {t[c], r[c]};
      end
   endtask : set_ready

   task automatic t_ready;
      for (int c = 0; c < 4; c++) begin
         set_ready(4'h1 << c, 4'h1 << c);
         cyc(3);
         chk("chan tx ready", {4'h0, ~(4'h1 << c)}, {4'h0, ctx_n});
         chk("chan rx ready", {4'h0, ~(4'h1 << c)}, {4'h0, crx_n});
         chk("ready pins", 8'h00, {6'h00, txr_n, rxr_n});
      end
      set_ready(4'h0, 4'h0);
      cyc(3);
      chk("ready pins idle", 8'h03, {6'h00, txr_n, rxr_n});
   endtask : t_ready
   task automatic t_status;
      set_ready(4'h5, 4'h3);
      sel_n = 1'b0;
      cyc(5);
      chk("status drive", 8'hc5, oe_n ? 8'hff : data);
      sel_n = 1'b1;
      cyc(5);
      chk("status off", 8'h01, {data[6:0], oe_n});
      set_ready(4'h0, 4'h0);
   endtask : t_status
   task automatic t_modem;
      int pulses;
      for (int k = 0; k < 8; k++) begin
         for (int c = 0; c < 4; c++) begin
            {core[c].rts_allow, ctrl[c].auto_rts_en, ctrl[c].rts_bit} = 3'(k);
            ctrl[c].dtr_bit = c[0];
         end
         cyc(2);
         chk("rts", {4'h0, {4{~(k[0] & (~k[1] | k[2]))}}}, {4'h0, rts_n});
         chk("dtr", 8'h05, {4'h0, dtr_n});
      end
      for (int c = 0; c < 4; c++) begin
         {ctrl[c].auto_cts_en, ctrl[c].cts_irq_en} = 2'b11;
      end
      {cts_on, dsr_on} = 8'h36;
      cyc(6);
      chk("cts dsr", 8'h36, {s_cts, s_dsr});
      chk("tx hold", 8'h0c, {4'h0, s_hold});
      pulses = 0;
      cts_on = 4'h0;
      repeat (8) begin
         cyc(1);
         pulses += $countones(s_chg);
      end
      chk("cts change", 8'h02, 8'(pulses));
   endtask : t_modem
   task automatic t_ir;
      logic [3:0] seen;
      ctrl[0].ir_en = 1'b1;
      cyc(3);
      chk("ir idle", 8'he0, {tx, irtx});
      seen = 4'h0;
      for (int c = 0; c < 2; c++) begin
         {core[c].tx_data, core[c].tx_bit_start} = 2'b01;
      end
      cyc(1);
      for (int c = 0; c < 2; c++) begin
         core[c].tx_bit_start = 1'b0;
      end
      repeat (40) begin
         cyc(1);
         seen |= irtx;
         chk("std tx low", 8'h00, {7'h00, tx[1]});
         chk("ir tx follows", {7'h00, irtx[0]}, {7'h00, tx[0]});
      end
      chk("ir pulses", 8'h03, {4'h0, seen});
      for (int c = 0; c < 2; c++) begin
         core[c].tx_data = 1'b1;
      end
      cyc(2);
      chk("ir rest", 8'he0, {tx, irtx});
   endtask : t_ir
   task automatic t_irrx;
      logic low_seen;
      cyc(6);
      chk("ir rx idle", 8'h0f, {4'h0, s_rx});
      low_seen = 1'b0;
      mark = 4'h5;
      repeat (8) begin
         cyc(1);
         low_seen |= ~s_rx[0];
      end
      mark = 4'h0;
      chk("ir rx decode", 8'h00, {6'h00, s_rx[2], ~low_seen});
      ctrl[0].rx_inv = 1'b1;
      cyc(80);
      chk("ir rx inverted", 8'h0f, {4'h0, s_rx});
      // Inverted transceiver: a mark pulls the pin low and must still decode
      low_seen = 1'b0;
      mark = 4'h1;
      repeat (8) begin
         cyc(1);
         low_seen |= ~s_rx[0];
      end
      mark = 4'h0;
      chk("ir rx inverted decode", 8'h00, {7'h00, ~low_seen});
   endtask : t_irrx

   initial begin
      for (int c = 0; c < 4; c++) begin
         ctrl[c] = '0;
         core[c] = '0;
         core[c].tx_data = 1'b1;
      end
      cyc(2);
      chk("reset pins", 8'hf0, {tx, irtx});
      cyc(4);
      i_rst_b = 1'b1;
      cyc(3);
      t_ready();
      t_status();
      t_modem();
      t_ir();
      t_irrx();
      close_out();
   end
endmodule : tb

bind qupin_top qupin_checker #(.CHANNELS(CHANNELS)) chk_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
   .i_tick16(i_tick16), .i_ctrl(i_ctrl), .i_core(i_core), .o_sense(o_sense), .o_tx(o_tx),
   .o_infrared_tx_out(o_infrared_tx_out), .i_rx(i_rx), .o_rts_n(o_rts_n), .i_cts_n(i_cts_n),
   .o_dtr_n(o_dtr_n), .i_dsr_n(i_dsr_n), .o_chan_tx_ready_n(o_chan_tx_ready_n),
   .o_chan_rx_ready_n(o_chan_rx_ready_n), .o_tx_ready_n(o_tx_ready_n),
   .o_rx_ready_n(o_rx_ready_n), .i_status_word_select_n(i_status_word_select_n),
   .o_data(o_data), .o_data_oe_n(o_data_oe_n));
